// ==== shared/eer_pkg.sv ====
package eer_pkg;
    // ********************************
    // Geometry and select code
    // ********************************
    localparam int          EER_ADDR_W      = 13;
    localparam int          EER_BYTE_BITS   = 8;
    localparam logic [3:0]  EER_ACK_SLOT    = 4'h8;
    localparam logic [3:0]  EER_LAST_BIT    = 4'h7;
    localparam logic [2:0]  EER_SEL_CHIP    = 3'h1;
    localparam int          EER_WP_ADDR_BIT = 15;
    localparam logic [7:0]  EER_ARRAY_INIT  = 8'hff;
    localparam logic [3:0]  EER_WP_INIT     = 4'h0;
    localparam logic [3:0]  EER_WP_PAD      = 4'h0;

    // ********************************
    // Host bit timing
    // ********************************
    localparam int EER_CLK_PERIOD_NS = 100;
    localparam int EER_SCL_PERIOD_NS = 10000;
    localparam int EER_QTR_CYC       = EER_SCL_PERIOD_NS / (4 * EER_CLK_PERIOD_NS);

    // ********************************
    // State types
    // ********************************
    typedef enum logic [3:0] {
        EER_D_IDLE, EER_D_SEL, EER_D_ACK_SEL, EER_D_AHI, EER_D_ACK_HI,
        EER_D_ALO, EER_D_ACK_LO, EER_D_RD_BYTE, EER_D_RD_ACK
    } eer_dev_state_e;

    typedef enum logic [2:0] {
        EER_H_IDLE, EER_H_START, EER_H_TX, EER_H_RX, EER_H_STOP
    } eer_host_state_e;

    typedef enum logic [1:0] {
        EER_STEP_SELW, EER_STEP_AHI, EER_STEP_ALO, EER_STEP_SELR
    } eer_step_e;
endpackage : eer_pkg

// ==== shared/eer_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface eer_link_if;
    logic scl;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic d_sda_o;
    logic d_sda_oe_n;
    logic sda;

    // Open-drain wired AND, pulled high when nobody drives low
    assign sda = ~((~m_sda_oe_n & ~m_sda_o) | (~d_sda_oe_n & ~d_sda_o));

    modport host   (output scl, output m_sda_o, output m_sda_oe_n, input sda);
    modport device (input scl, input sda, output d_sda_o, output d_sda_oe_n);
endinterface : eer_link_if
`default_nettype wire

// ==== core/eer_device.sv ====
//
// Behaviour
// RL1 - reads ignore write protection state
// RL2 - completed read advances counter by one; protection register reads leave the counter unchanged
// RL3 - release SDA, sample master ack slot nine
// RL4 - withheld acknowledge ends read, go standby
// RL5 - random read: dummy write, repeated start
// RL6 - ack read select, send loaded-address byte
// RL7 - single read ends with nack, stop
// RL8 - current read: ack, send counter byte, increment
// RL9 - master ack continues with next address
// RL10 - stream ends with nack then stop
// RL11 - counter wraps from last address to 00h
// RL12 - address msb set reads protection register
// RL13 - protection register upper nibble reads zero
// RL14 - further protection reads repeat same value
// RL15 - no protection read during write cycle
// RL16 - array starts FFh, protection 00h
// RL17 - select bit eight: 1 read, 0 write
// RL18 - write select then two acked address bytes
// RL19 - protection bits: enable, size, lock
// RL20 - write cycle: SDA released, requests ignored
// RL21 - 8 Kbyte counter, data MSB first
// RL22 - after nack, wait for next start
//
`timescale 1ns/1ps
`default_nettype none
module eer_device #(
    parameter logic [3:0] SEL_TYPE = 4'h6,             // Arbitrary type code
    parameter int          ADDR_W   = eer_pkg::EER_ADDR_W
) (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_rst,
    eer_link_if.device                   link,
    input  wire logic                    i_write_busy,
    input  wire logic                    i_mem_we,
    input  wire logic [ADDR_W-1:0]       i_mem_addr,
    input  wire logic [7:0]              i_mem_data,
    input  wire logic                    i_wp_we,
    input  wire logic [7:0]              i_wp_data,
    output logic      [7:0]              o_wp_setting,
    output logic      [ADDR_W-1:0]       o_addr_counter,
    output logic                         o_reading
);
    import eer_pkg::*;

    // ********************************
    // Storage
    // ********************************
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    logic [3:0] wp;

    // Array and protection register, loaded by the write path
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < (1<<ADDR_W); i++) begin
                mem[i] <= EER_ARRAY_INIT; // RL16
            end
            wp <= EER_WP_INIT; // RL16
        end else begin
            if (i_mem_we) begin
                mem[i_mem_addr] <= i_mem_data;
            end
            if (i_wp_we && !wp[0]) begin
                wp <= i_wp_data[3:0]; // RL19
            end
        end
    end

    // Byte to send: protection register or array
    function automatic logic [7:0] rd_byte(input logic [ADDR_W-1:0] a, input logic sel);
        rd_byte = sel ? {EER_WP_PAD, wp} : mem[a]; // RL1 RL12 RL13
    endfunction : rd_byte

    // ********************************
    // Pin synchronisers and bus events
    // ********************************
    logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;

    // Two flops per pin, then one delay for edges
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_q <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_m <= link.scl;
            scl_s <= scl_m;
            scl_q <= scl_s;
            sda_m <= link.sda;
            sda_s <= sda_m;
            sda_q <= sda_s;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;

    // Edge and condition decode
    always_comb begin
        scl_rise  = scl_s & ~scl_q;
        scl_fall  = ~scl_s & scl_q;
        bus_start = scl_s & scl_q & sda_q & ~sda_s;
        bus_stop  = scl_s & scl_q & ~sda_q & sda_s;
    end

    // ********************************
    // Protocol engine
    // ********************************
    eer_dev_state_e    state, next_state;
    logic [3:0]        cnt, next_cnt;
    logic [7:0]        sh, next_sh;
    logic [7:0]        addr_hi, next_addr_hi;
    logic [ADDR_W-1:0] addr, next_addr;
    logic              wp_sel, next_wp_sel;
    logic              rw, next_rw;
    logic              mack, next_mack;
    logic              sda_low, next_sda_low;
    logic [ADDR_W-1:0] inc_addr;
    logic [7:0]        nb;

    // Next-state logic
    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_sh      = sh;
        next_addr_hi = addr_hi;
        next_addr    = addr;
        next_wp_sel  = wp_sel;
        next_rw      = rw;
        next_mack    = mack;
        next_sda_low = sda_low;
        inc_addr     = ADDR_W'(addr + 1'b1); // RL11 RL21
        nb           = 8'h00;
        if (i_write_busy) begin
            next_state   = EER_D_IDLE; // RL15 RL20
            next_sda_low = 1'b0;
        end else if (bus_start) begin
            next_state   = EER_D_SEL; // RL22
            next_cnt     = 4'h0;
            next_sda_low = 1'b0;
        end else if (bus_stop) begin
            next_state   = EER_D_IDLE;
            next_sda_low = 1'b0;
            next_wp_sel  = 1'b0;
        end else begin
            case (state)
                EER_D_SEL, EER_D_AHI, EER_D_ALO: begin
                    if (scl_rise && cnt != EER_ACK_SLOT) begin
                        next_sh  = {sh[6:0], sda_s};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == EER_ACK_SLOT) begin
                        next_sda_low = 1'b1;
                        if (state == EER_D_SEL) begin
                            next_rw    = sh[0]; // RL17
                            next_state = EER_D_ACK_SEL;
                            if (sh[7:1] != {SEL_TYPE, EER_SEL_CHIP}) begin
                                next_state   = EER_D_IDLE;
                                next_sda_low = 1'b0;
                            end
                        end else if (state == EER_D_AHI) begin
                            next_addr_hi = sh; // RL18
                            next_state   = EER_D_ACK_HI;
                        end else begin
                            next_addr   = ADDR_W'({addr_hi, sh}); // RL18
                            next_wp_sel = addr_hi[EER_WP_ADDR_BIT-8]; // RL12
                            next_state  = EER_D_ACK_LO;
                        end
                    end
                end
                EER_D_ACK_SEL: begin
                    if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (rw) begin
                            nb           = rd_byte(addr, wp_sel); // RL6 RL8
                            next_sh      = nb;
                            next_sda_low = ~nb[7]; // RL21
                            next_state   = EER_D_RD_BYTE;
                        end else begin
                            next_sda_low = 1'b0;
                            next_state   = EER_D_AHI; // RL18
                        end
                    end
                end
                EER_D_ACK_HI: begin
                    if (scl_fall) begin
                        next_sda_low = 1'b0;
                        next_cnt     = 4'h0;
                        next_state   = EER_D_ALO;
                    end
                end
                EER_D_ACK_LO: begin
                    if (scl_fall) begin
                        next_sda_low = 1'b0;
                        next_state   = EER_D_IDLE;
                    end
                end
                EER_D_RD_BYTE: begin
                    if (scl_fall) begin
                        if (cnt == EER_LAST_BIT) begin
                            next_sda_low = 1'b0; // RL3
                            next_state   = EER_D_RD_ACK;
                        end else begin
                            next_sh      = {sh[6:0], 1'b0}; // RL21
                            next_sda_low = ~sh[6];
                            next_cnt     = cnt + 4'h1;
                        end
                    end
                end
                EER_D_RD_ACK: begin
                    if (scl_rise) begin
                        next_mack = ~sda_s; // RL3
                    end else if (scl_fall) begin
                        if (!wp_sel) begin
                            next_addr = inc_addr; // RL2 RL8 RL11
                        end
                        if (mack) begin
                            nb           = rd_byte(wp_sel ? addr : inc_addr, wp_sel); // RL9 RL14
                            next_sh      = nb;
                            next_sda_low = ~nb[7];
                            next_cnt     = 4'h0;
                            next_state   = EER_D_RD_BYTE;
                        end else begin
                            next_state = EER_D_IDLE; // RL4 RL22
                        end
                    end
                end
                default: begin
                    next_state = EER_D_IDLE;
                end
            endcase
        end
    end

    // Engine registers
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state   <= EER_D_IDLE;
            cnt     <= 4'h0;
            sh      <= 8'h00;
            addr_hi <= 8'h00;
            addr    <= '0;
            wp_sel  <= 1'b0;
            rw      <= 1'b0;
            mack    <= 1'b0;
            sda_low <= 1'b0;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            sh      <= next_sh;
            addr_hi <= next_addr_hi;
            addr    <= next_addr;
            wp_sel  <= next_wp_sel;
            rw      <= next_rw;
            mack    <= next_mack;
            sda_low <= next_sda_low;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign link.d_sda_o     = 1'b0;
    assign link.d_sda_oe_n  = ~sda_low; // RL20
    assign o_wp_setting     = {EER_WP_PAD, wp};
    assign o_addr_counter   = addr;
    assign o_reading        = (state == EER_D_RD_BYTE) || (state == EER_D_RD_ACK);
endmodule : eer_device
`default_nettype wire

// ==== core/eer_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module eer_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst,
    input  wire logic         i_in_valid,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_in_ready,
    output logic              o_out_valid,
    output logic [W-1:0]      o_out_data,
    input  wire logic         i_out_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [0:D-1];
    logic [AW:0]  wr, next_wr, rd, next_rd, cnt, next_cnt;
    logic         push, pop;

    // Pointer and fill count update
    always_comb begin
        o_in_ready  = (cnt != (AW+1)'(D));
        o_out_valid = (cnt != '0);
        push        = i_in_valid & o_in_ready;
        pop         = i_out_ready & o_out_valid;
        next_wr     = push ? ((wr == (AW+1)'(D-1)) ? '0 : wr + 1'b1) : wr;
        next_rd     = pop ? ((rd == (AW+1)'(D-1)) ? '0 : rd + 1'b1) : rd;
        next_cnt    = cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Pointers and storage
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wr  <= '0;
            rd  <= '0;
            cnt <= '0;
        end else begin
            wr  <= next_wr;
            rd  <= next_rd;
            cnt <= next_cnt;
            if (push) begin
                mem[wr[AW-1:0]] <= i_in_data;
            end
        end
    end

    assign o_out_data = mem[rd[AW-1:0]];
endmodule : eer_fifo

module eer_host #(
    parameter logic [3:0] SEL_TYPE   = 4'h6,           // Arbitrary type code
    parameter int          QTR_CYC    = eer_pkg::EER_QTR_CYC,
    parameter int          FIFO_DEPTH = 16
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    eer_link_if.host         link,
    input  wire logic        i_cmd_valid,
    input  wire logic        i_cmd_random,
    input  wire logic [15:0] i_cmd_addr,
    input  wire logic [7:0]  i_cmd_count,
    output logic             o_cmd_ready,
    output logic             o_rd_valid,
    output logic [7:0]       o_rd_data,
    input  wire logic        i_rd_ready,
    output logic             o_nack
);
    import eer_pkg::*;

    // ********************************
    // Quarter-bit tick and SDA sync
    // ********************************
    logic [15:0] div;
    logic        tick, sda_m, sda_s;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            div   <= 16'h0000;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            div   <= tick ? 16'h0000 : div + 16'h0001;
            sda_m <= link.sda;
            sda_s <= sda_m;
        end
    end
    assign tick = (div == 16'(QTR_CYC - 1));

    // ********************************
    // Sequencer
    // ********************************
    eer_host_state_e hs, next_hs;
    eer_step_e       step, next_step;
    logic [1:0]      ph, next_ph;
    logic [3:0]      cnt, next_cnt;
    logic [7:0]      sh, next_sh, remain, next_remain;
    logic [15:0]     addr, next_addr;
    logic            scl, next_scl, sda_low, next_sda_low;
    logic            ack_ok, next_ack_ok, nack, next_nack;
    logic            push, next_push, f_ready;

    always_comb begin
        next_hs      = hs;
        next_step    = step;
        next_ph      = ph;
        next_cnt     = cnt;
        next_sh      = sh;
        next_remain  = remain;
        next_addr    = addr;
        next_scl     = scl;
        next_sda_low = sda_low;
        next_ack_ok  = ack_ok;
        next_nack    = 1'b0;
        next_push    = 1'b0;
        if (hs == EER_H_IDLE) begin
            next_scl     = 1'b1;
            next_sda_low = 1'b0;
            if (i_cmd_valid) begin
                next_addr   = i_cmd_addr;
                next_remain = (i_cmd_count == 8'h00) ? 8'h01 : i_cmd_count;
                next_step   = i_cmd_random ? EER_STEP_SELW : EER_STEP_SELR; // RL5
                next_ph     = 2'h0;
                next_hs     = EER_H_START;
            end
        end else if (tick && !(hs == EER_H_RX && ph == 2'h0 && cnt == 4'h0 && !f_ready)) begin
            next_ph = ph + 2'h1;
            case (hs)
                EER_H_START: begin
                    case (ph)
                        2'h0: next_sda_low = 1'b0;
                        2'h1: next_scl = 1'b1;
                        2'h2: next_sda_low = 1'b1;
                        default: begin
                            next_scl = 1'b0;
                            next_cnt = 4'h0;
                            next_sh  = {SEL_TYPE, EER_SEL_CHIP, step == EER_STEP_SELR}; // RL17
                            next_hs  = EER_H_TX;
                        end
                    endcase
                end
                EER_H_TX: begin
                    case (ph)
                        2'h0: next_sda_low = (cnt != EER_ACK_SLOT) & ~sh[7];
                        2'h1: next_scl = 1'b1;
                        2'h2: next_ack_ok = ~sda_s;
                        default: begin
                            next_scl = 1'b0;
                            if (cnt != EER_ACK_SLOT) begin
                                next_sh  = {sh[6:0], 1'b0};
                                next_cnt = cnt + 4'h1;
                            end else if (!ack_ok) begin
                                next_nack = 1'b1;
                                next_hs   = EER_H_STOP;
                            end else begin
                                next_cnt = 4'h0;
                                case (step)
                                    EER_STEP_SELW: begin
                                        next_sh   = addr[15:8];
                                        next_step = EER_STEP_AHI;
                                    end
                                    EER_STEP_AHI: begin
                                        next_sh   = addr[7:0];
                                        next_step = EER_STEP_ALO;
                                    end
                                    EER_STEP_ALO: begin
                                        next_step = EER_STEP_SELR;
                                        next_hs   = EER_H_START; // RL5
                                    end
                                    default: next_hs = EER_H_RX;
                                endcase
                            end
                        end
                    endcase
                end
                EER_H_RX: begin
                    case (ph)
                        2'h0: next_sda_low = (cnt == EER_ACK_SLOT) && (remain != 8'h01); // RL7 RL9 RL10
                        2'h1: next_scl = 1'b1;
                        2'h2: begin
                            if (cnt != EER_ACK_SLOT) begin
                                next_sh = {sh[6:0], sda_s};
                            end
                        end
                        default: begin
                            next_scl = 1'b0;
                            if (cnt != EER_ACK_SLOT) begin
                                next_cnt = cnt + 4'h1;
                            end else begin
                                next_push   = 1'b1;
                                next_cnt    = 4'h0;
                                next_remain = remain - 8'h01;
                                if (remain == 8'h01) begin
                                    next_hs = EER_H_STOP; // RL7 RL10
                                end
                            end
                        end
                    endcase
                end
                default: begin
                    case (ph)
                        2'h0: next_sda_low = 1'b1;
                        2'h1: next_scl = 1'b1;
                        2'h2: next_sda_low = 1'b0;
                        default: next_hs = EER_H_IDLE;
                    endcase
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            hs      <= EER_H_IDLE;
            step    <= EER_STEP_SELR;
            ph      <= 2'h0;
            cnt     <= 4'h0;
            sh      <= 8'h00;
            remain  <= 8'h00;
            addr    <= 16'h0000;
            scl     <= 1'b1;
            sda_low <= 1'b0;
            ack_ok  <= 1'b0;
            nack    <= 1'b0;
            push    <= 1'b0;
        end else begin
            hs      <= next_hs;
            step    <= next_step;
            ph      <= next_ph;
            cnt     <= next_cnt;
            sh      <= next_sh;
            remain  <= next_remain;
            addr    <= next_addr;
            scl     <= next_scl;
            sda_low <= next_sda_low;
            ack_ok  <= next_ack_ok;
            nack    <= next_nack;
            push    <= next_push;
        end
    end

    // ********************************
    // Read data buffer
    // ********************************
    eer_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_rst       (i_rst),
        .i_in_valid  (push),
        .i_in_data   (sh),
        .o_in_ready  (f_ready),
        .o_out_valid (o_rd_valid),
        .o_out_data  (o_rd_data),
        .i_out_ready (i_rd_ready)
    );

    assign link.scl        = scl;
    assign link.m_sda_o    = 1'b0;
    assign link.m_sda_oe_n = ~sda_low;
    assign o_cmd_ready     = (hs == EER_H_IDLE);
    assign o_nack          = nack;
endmodule : eer_host
`default_nettype wire

// ==== verif/eer_link_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********************************
// Link checks
// ********************************
module eer_link_assertions (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic scl,
    input wire logic m_sda_o,
    input wire logic m_sda_oe_n,
    input wire logic d_sda_o,
    input wire logic d_sda_oe_n,
    input wire logic sda
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // Clock phases, drive timing, open drain
    AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*4])
        else $error("scl high too short");
    AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*4])
        else $error("scl low too short");
    AST_DEV_MOVE_LOW: assert property ($changed(d_sda_oe_n) |-> !scl)
        else $error("device moved sda while scl high");
    AST_DEV_SYNC_LAG: assert property ($fell(scl) |=> $stable(d_sda_oe_n) [*2])
        else $error("device drove before sync delay");
    AST_DEV_RELEASE: assert property ($fell(d_sda_oe_n) |-> ##[1:400] $rose(d_sda_oe_n))
        else $error("device held sda too long");
    AST_START_FREE: assert property (scl && $past(scl) && $fell(sda) |-> d_sda_oe_n)
        else $error("device drove sda at start");
    AST_DEV_OPEN_DRAIN: assert property (!d_sda_oe_n |-> !d_sda_o)
        else $error("device drove sda high");
    AST_HOST_OPEN_DRAIN: assert property (!m_sda_oe_n |-> !m_sda_o)
        else $error("host drove sda high");
endmodule : eer_link_assertions
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; $display("CHECK FAILED %0t mismatch got %h want %h", $time, a, b); end end
// ********************************
// Read path bench
// ********************************
module testbench;
    logic i_sys_clk = 0, i_rst = 1, cv = 0, crnd = 0, rdy = 0, busy = 0, mwe = 0, wwe = 0, rv, cr, nk_o, rdg;
    logic [15:0] caddr = '0;
    logic [7:0]  ccnt = '0, mdata = '0, wdata = '0, wp = '0, rdat, wps;
    logic [12:0] maddr = '0, cur = '0, ctr;
    logic [7:0]  mem [8192];
    int          failures = 0, comparisons = 0;
    eer_link_if link ();
    // Clock
    always #50 i_sys_clk = ~i_sys_clk;
    eer_host #(.QTR_CYC(8)) eer_host_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(link), .i_cmd_valid(cv),
        .i_cmd_random(crnd), .i_cmd_addr(caddr), .i_cmd_count(ccnt), .o_cmd_ready(cr), .o_rd_valid(rv),
        .o_rd_data(rdat), .i_rd_ready(rdy), .o_nack(nk_o));
    eer_device eer_device_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(link), .i_write_busy(busy),
        .i_mem_we(mwe), .i_mem_addr(maddr), .i_mem_data(mdata), .i_wp_we(wwe), .i_wp_data(wdata),
        .o_wp_setting(wps), .o_addr_counter(ctr), .o_reading(rdg));
    eer_link_assertions eer_link_assertions_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .scl(link.scl),
        .m_sda_o(link.m_sda_o), .m_sda_oe_n(link.m_sda_oe_n), .d_sda_o(link.d_sda_o),
        .d_sda_oe_n(link.d_sda_oe_n), .sda(link.sda));
    // Verdict and end of run
    task automatic stop_test;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    // Expected read byte: protection register or array model at the counter
    function automatic logic [7:0] exp_byte(input logic prot);
        return prot ? wp : mem[cur];
    endfunction : exp_byte
    // One read command, bytes checked against the model
    task automatic rd(input logic r, input logic [15:0] a, input int n, input logic nak, input int stall);
        int i, got;
        logic nk;
        got = 0;
        nk = 0;
        if (r) cur = a[12:0]; // Dummy write loads the counter, protection reads too
        @(posedge i_sys_clk);
        {cv, crnd, caddr, ccnt} <= {1'b1, r, a, n[7:0]};
        @(posedge i_sys_clk);
        cv <= 1'b0;
        for (i = 0; i < 20000; i++) begin
            @(negedge i_sys_clk);
            if (rv && rdy) begin
                `CHK(rdat, exp_byte(r && a[15]))
                if (!(r && a[15])) cur++;
                got++;
            end
            nk |= nk_o;
            if (cr && got >= (nak ? 0 : n)) break;
            @(posedge i_sys_clk);
            rdy <= (i > stall) && ($urandom % 3 != 0);
        end
        if (i == 20000) begin
            failures++;
            stop_test();
        end
        `CHK(nk, nak)
        `CHK(ctr, cur)
        `CHK(rdg, 1'b0)
        $display("read test done at %0t", $time);
    endtask : rd
    // Protection setting write and readback
    task automatic wpw(input logic [7:0] d);
        @(posedge i_sys_clk);
        {wwe, wdata} <= {1'b1, d};
        @(posedge i_sys_clk);
        wwe <= 1'b0;
        if (!wp[0]) wp = {4'h0, d[3:0]};
        @(negedge i_sys_clk);
        `CHK(wps, wp)
        $display("protection test done at %0t", $time);
    endtask : wpw
    // Main sequence
    initial begin
        int k;
        logic [12:0] ma;
        k = $urandom(32'h9ee9d5f4);
        foreach (mem[j]) mem[j] = 8'hff;
        repeat (20) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (10) @(posedge i_sys_clk);
        rd(1'b1, 16'h1fff, 3, 1'b0, 0);
        rd(1'b1, 16'h8000, 2, 1'b0, 0);
        wpw(8'hfa);
        wpw(8'hfb);
        wpw(8'h08);
        rd(1'b1, 16'hc123, 3, 1'b0, 0);
        for (k = 0; k < 40; k++) begin
            ma = 13'h1ff8 + 13'($urandom % 16);
            @(posedge i_sys_clk);
            {mwe, maddr, mdata} <= {1'b1, ma, 8'($urandom)};
            #1 mem[ma] = mdata;
        end
        @(posedge i_sys_clk);
        mwe <= 1'b0;
        for (k = 0; k < 12; k++) rd(1'($urandom), {3'h0, 13'h1ff8 + 13'($urandom % 16)}, 1 + $urandom % 4, 1'b0, 0);
        rd(1'b1, 16'h0100, 20, 1'b0, 7000);
        @(posedge i_sys_clk) busy <= 1'b1;
        rd(1'b0, 16'h0, 1, 1'b1, 0);
        @(posedge i_sys_clk) busy <= 1'b0;
        rd(1'b0, 16'h0, 2, 1'b0, 0);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
